// file: core/tmc_map.svh
// Constants for the backplane message and command channel handler
// Behaviour
// - Connect code per channel: 00 monitor, 01 IC loop, 10 B constant, 11 B pattern
// - Terminal mode has message channels 0 and 1; otherwise only channel 0
// - Message channel 0 stays usable for an external layer-1 transceiver
// - Transmitter repeats its byte every frame until the receiver acknowledges
// - Control bit 0 forces handshake bit idle 1; 1 lets protocol drive it
// - Message-active status reads 1 during a transfer, 0 when idle
// - Loaded data plus transmit control 1 drives transmit handshake active low
// - Active transmit handshake stores byte in receive register, sets data-received
// - Receive control 1 acknowledges first byte with 0; transmitter flags acknowledged
// - One inactive frame then active marks next byte; receiver stores and flags it
// - After read, receiver blinks handshake inactive one frame; transmitter flags acknowledge
// - No timeout waits on processor reactions
// - Transmit handshake inactive two frames raises end-of-reception
// - Transmit control cleared with receive handshake inactive two frames closes transfer; active status drops
// - Receive handshake inactive two frames mid-transfer raises abort at transmitter
// - Status holds per channel received, end, acknowledged, abort flags; interrupt enable bit
// - Command channel 0 carries a 4-bit code via receive and transmit registers
// - Channel 0 code accepted after two equal frames; raises code-change status
// - Channel 0 transmit code is sent every frame until rewritten
// - Channel 2 bits are left for layer-2 bus arbitration
// - Command channel 1 carries six bits each way, terminal mode only
// - Any channel 1 code change raises status at once
`ifndef TMC_MAP_SVH
`define TMC_MAP_SVH
// Register byte offsets
`define TMC_A_CTRL    8'h00
`define TMC_A_MCTL    8'h04
`define TMC_A_MSTAT   8'h08
`define TMC_A_GSTAT   8'h0C
`define TMC_A_MTX0    8'h10
`define TMC_A_MRX0    8'h14
`define TMC_A_MTX1    8'h18
`define TMC_A_MRX1    8'h1C
`define TMC_A_CMD0_RECEIVE_REG    8'h20
`define TMC_A_CMD0_TRANSMIT_REG    8'h24
`define TMC_A_CMD1_RECEIVE_REG    8'h28
`define TMC_A_CMD1_TRANSMIT_REG    8'h2C
`define TMC_A_INTERRUPT_STATUS_REG    8'h30
`define TMC_A_BCR1    8'h34
`define TMC_A_BCR2    8'h38
`define TMC_A_CR1     8'h3C
`define TMC_A_CR2     8'h40
// Control register fields
`define TMC_C_TMS     0
`define TMC_C_L1D     1
`define TMC_C_CC1     3:2
`define TMC_C_CC2     5:4
// Message control fields, three bits per channel
`define TMC_M_MRC     0
`define TMC_M_MXC     1
`define TMC_M_MIE     2
`define TMC_M_W       3
// Message status flag positions, four per channel
`define TMC_S_MDR     0
`define TMC_S_MER     1
`define TMC_S_MDA     2
`define TMC_S_MAB     3
`define TMC_S_W       4
// Command change flags
`define TMC_I_CI0     0
`define TMC_I_CI1     1
// Frame layout, bit index within frame
`define TMC_FR_BITS   7'd96
`define TMC_FR_B      0
`define TMC_FR_IC     32
`define TMC_FR_MON    16
`define TMC_FR_CI0    26
`define TMC_FR_CI1    56
`define TMC_FR_MR     30
`define TMC_FR_MX     31
`define TMC_FR_CH1    32
`define TMC_RESP_OK   2'h0
`define TMC_RESP_ERR  2'h2
`endif

// file: core/tmc_pkg.sv
// Types for the backplane message and command channel handler
package tmc_pkg;
  typedef enum logic [1:0] {
    TMC_TX_IDLE  = 2'h0,
    TMC_TX_WAIT  = 2'h1,
    TMC_TX_ACKED = 2'h3,
    TMC_TX_BLINK = 2'h2
  } tmc_txst_e;
  typedef struct packed {
    tmc_txst_e  st;
    logic       seen;
    logic [7:0] txd;
    logic       tx_new;
    logic       mac;
    logic [7:0] rxd;
    logic       unread;
    logic       ack_due;
    logic       mr_out;
    logic       blink;
    logic       in_msg;
    logic       mx_p;
    logic       mr_p;
    logic [3:0] flags;
  } tmc_mon_s;
  typedef struct packed {
    logic clk;
    logic fs;
    logic dat;
  } tmc_link_s;
endpackage

// file: core/tmc_top.sv
// Backplane message, command and channel-connect handler with AXI4-Lite registers
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ns
`include "tmc_map.svh"
module tmc_top (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [7:0]        s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [7:0]        s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  input  wire tmc_pkg::tmc_link_s link_i,
  output logic                   link_dout,
  output logic                   link_doe
);
  import tmc_pkg::*;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a[1:0] == 2'h0) && (a <= `TMC_A_CR2);
  endfunction

  // ==========================================================
  // Link sampler
  tmc_link_s   s1_q, s2_q, s3_q;
  logic [6:0]  bit_q, bit_d, tx_idx;
  logic [95:0] rxv_q, rxv_d;
  logic [95:0] txv, oev;
  logic        dout_q, dout_d, doe_q, doe_d;
  logic        frame_tick;

  assign frame_tick = s2_q.fs & ~s3_q.fs;

  always_comb begin
    bit_d  = bit_q;
    rxv_d  = rxv_q;
    dout_d = dout_q;
    doe_d  = doe_q;
    // Bit 0 launches on the falling edge that meets frame sync
    tx_idx = frame_tick ? 7'h00 : bit_q;
    if (frame_tick) begin
      bit_d = 7'h00;
    end else if (s2_q.clk & ~s3_q.clk) begin
      if (bit_q < `TMC_FR_BITS) begin
        rxv_d[bit_q] = s2_q.dat;
        bit_d        = bit_q + 7'h01;
      end
    end
    if (~s2_q.clk & s3_q.clk) begin
      dout_d = (tx_idx < `TMC_FR_BITS) ? txv[tx_idx] : 1'b1;
      doe_d  = (tx_idx < `TMC_FR_BITS) ? oev[tx_idx] : 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s1_q   <= '{clk: 1'b0, fs: 1'b0, dat: 1'b1};
      s2_q   <= '{clk: 1'b0, fs: 1'b0, dat: 1'b1};
      s3_q   <= '{clk: 1'b0, fs: 1'b0, dat: 1'b1};
      bit_q  <= `TMC_FR_BITS;
      rxv_q  <= '1;
      dout_q <= 1'b1;
      doe_q  <= 1'b0;
    end else begin
      s1_q   <= link_i;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      bit_q  <= bit_d;
      rxv_q  <= rxv_d;
      dout_q <= dout_d;
      doe_q  <= doe_d;
    end
  end

  assign link_dout = dout_q;
  assign link_doe  = doe_q;

  // ==========================================================
  // Registers, bus and channel protocol
  tmc_mon_s    mon_q [2];
  tmc_mon_s    mon_d [2];
  logic [5:0]  ctrl_q, ctrl_d;
  logic [5:0]  mctl_q, mctl_d;
  logic [3:0]  cmd0_receive_reg_q, cmd0_receive_reg_d, cmd0_transmit_reg_q, cmd0_transmit_reg_d, ci0p_q, ci0p_d;
  logic [5:0]  cmd1_receive_reg_q, cmd1_receive_reg_d, cmd1_transmit_reg_q, cmd1_transmit_reg_d;
  logic [1:0]  interrupt_status_reg_q, interrupt_status_reg_d;
  logic [7:0]  bcr_q [2];
  logic [7:0]  bcr_d [2];
  logic [7:0]  crr_q [2];
  logic [7:0]  crr_d [2];
  logic [7:0]  crw_q [2];
  logic [7:0]  crw_d [2];
  logic        awh_q, awh_d, wh_q, wh_d, bv_q, bv_d, rv_q, rv_d;
  logic [7:0]  awa_q, awa_d;
  logic [7:0]  wd_q, wd_d;
  logic        ws_q, ws_d;
  logic [1:0]  br_q, br_d, rr_q, rr_d;
  logic [31:0] rd_q, rd_d;
  logic        term, wr_go, rd_go;
  logic [1:0]  cc [2];

  assign term          = ~ctrl_q[`TMC_C_TMS];
  assign cc[0]         = ctrl_q[`TMC_C_CC1];
  assign cc[1]         = ctrl_q[`TMC_C_CC2];
  assign s_axi_awready = ~awh_q & ~bv_q;
  assign s_axi_wready  = ~wh_q & ~bv_q;
  assign s_axi_arready = ~rv_q;
  assign s_axi_bvalid  = bv_q;
  assign s_axi_bresp   = br_q;
  assign s_axi_rvalid  = rv_q;
  assign s_axi_rresp   = rr_q;
  assign s_axi_rdata   = rd_q;
  assign wr_go         = awh_q & wh_q & ~bv_q;
  assign rd_go         = s_axi_arvalid & ~rv_q;

  // Outgoing frame image from current state
  always_comb begin
    txv = '1;
    oev = '0;
    for (int c = 0; c < 2; c++) begin
      if (c == 0 || term) begin
        txv[`TMC_FR_MON + c*`TMC_FR_CH1 +: 8] = mon_q[c].txd;
        txv[`TMC_FR_MR + c*`TMC_FR_CH1]       = mon_q[c].mr_out;
        txv[`TMC_FR_MX + c*`TMC_FR_CH1]       = (mon_q[c].st == TMC_TX_IDLE) || (mon_q[c].st == TMC_TX_BLINK);
        oev[`TMC_FR_MON + c*`TMC_FR_CH1 +: 8] = '1;
        oev[`TMC_FR_MR + c*`TMC_FR_CH1]       = 1'b1;
        oev[`TMC_FR_MX + c*`TMC_FR_CH1]       = 1'b1;
      end
      if (term && cc[c] == 2'h1) begin
        txv[`TMC_FR_IC + c*8 +: 8] = crw_q[c];
        oev[`TMC_FR_IC + c*8 +: 8] = '1;
      end else if (term && cc[c][1]) begin
        txv[`TMC_FR_B + c*8 +: 8]  = crw_q[c];
        oev[`TMC_FR_B + c*8 +: 8]  = '1;
      end
    end
    txv[`TMC_FR_CI0 +: 4] = cmd0_transmit_reg_q;
    oev[`TMC_FR_CI0 +: 4] = '1;
    if (term) begin
      txv[`TMC_FR_CI1 +: 6] = cmd1_transmit_reg_q;
      oev[`TMC_FR_CI1 +: 6] = '1;
    end
    // channel 2 left undriven for arbitration
  end

  always_comb begin
    logic [7:0] rb;
    logic       mi, ri;
    logic [3:0] c0;
    rb     = 8'h00;
    mi     = 1'b1;
    ri     = 1'b1;
    c0     = rxv_q[`TMC_FR_CI0 +: 4];
    mon_d  = mon_q;
    ctrl_d = ctrl_q;
    mctl_d = mctl_q;
    cmd0_receive_reg_d = cmd0_receive_reg_q;
    cmd0_transmit_reg_d = cmd0_transmit_reg_q;
    ci0p_d = ci0p_q;
    cmd1_receive_reg_d = cmd1_receive_reg_q;
    cmd1_transmit_reg_d = cmd1_transmit_reg_q;
    interrupt_status_reg_d = interrupt_status_reg_q;
    bcr_d  = bcr_q;
    crr_d  = crr_q;
    crw_d  = crw_q;
    awh_d  = awh_q;
    wh_d   = wh_q;
    bv_d   = bv_q;
    rv_d   = rv_q;
    awa_d  = awa_q;
    wd_d   = wd_q;
    ws_d   = ws_q;
    br_d   = br_q;
    rr_d   = rr_q;
    rd_d   = rd_q;
    // Bus write side
    if (s_axi_awvalid && s_axi_awready) begin
      awh_d = 1'b1;
      awa_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      wh_d = 1'b1;
      wd_d = s_axi_wdata[7:0];
      ws_d = s_axi_wstrb[0];
    end
    if (bv_q && s_axi_bready) begin
      bv_d = 1'b0;
    end
    if (wr_go) begin
      awh_d = 1'b0;
      wh_d  = 1'b0;
      bv_d  = 1'b1;
      br_d  = is_mapped(awa_q) ? `TMC_RESP_OK : `TMC_RESP_ERR;
      if (ws_q) begin
        case (awa_q)
          `TMC_A_CTRL:  ctrl_d = wd_q[5:0];
          `TMC_A_MCTL:  mctl_d = wd_q[5:0];
          `TMC_A_MSTAT: begin
            mon_d[0].flags = mon_q[0].flags & ~wd_q[3:0];
            mon_d[1].flags = mon_q[1].flags & ~wd_q[7:4];
          end
          `TMC_A_MTX0:  begin
            mon_d[0].txd    = wd_q;
            mon_d[0].tx_new = 1'b1;
          end
          `TMC_A_MTX1:  begin
            mon_d[1].txd    = wd_q;
            mon_d[1].tx_new = 1'b1;
          end
          `TMC_A_CMD0_TRANSMIT_REG:  cmd0_transmit_reg_d = wd_q[3:0];
          `TMC_A_CMD1_TRANSMIT_REG:  cmd1_transmit_reg_d = wd_q[5:0];
          `TMC_A_INTERRUPT_STATUS_REG:  interrupt_status_reg_d = interrupt_status_reg_q & ~wd_q[1:0];
          `TMC_A_CR1:   crw_d[0] = wd_q;
          `TMC_A_CR2:   crw_d[1] = wd_q;
          default: ;
        endcase
      end
    end
    // Bus read side; reading received data marks it consumed
    if (rv_q && s_axi_rready) begin
      rv_d = 1'b0;
    end
    if (rd_go) begin
      case (s_axi_araddr)
        `TMC_A_CTRL:  rb = {2'h0, ctrl_q};
        `TMC_A_MCTL:  rb = {2'h0, mctl_q};
        `TMC_A_MSTAT: rb = {mon_q[1].flags, mon_q[0].flags};
        `TMC_A_GSTAT: rb = {6'h00, mon_q[1].mac, mon_q[0].mac};
        `TMC_A_MTX0:  rb = mon_q[0].txd;
        `TMC_A_MRX0:  begin
          rb               = mon_q[0].rxd;
          mon_d[0].unread  = 1'b0;
        end
        `TMC_A_MTX1:  rb = mon_q[1].txd;
        `TMC_A_MRX1:  begin
          rb               = mon_q[1].rxd;
          mon_d[1].unread  = 1'b0;
        end
        `TMC_A_CMD0_RECEIVE_REG:  rb = {4'h0, cmd0_receive_reg_q};
        `TMC_A_CMD0_TRANSMIT_REG:  rb = {4'h0, cmd0_transmit_reg_q};
        `TMC_A_CMD1_RECEIVE_REG:  rb = {2'h0, cmd1_receive_reg_q};
        `TMC_A_CMD1_TRANSMIT_REG:  rb = {2'h0, cmd1_transmit_reg_q};
        `TMC_A_INTERRUPT_STATUS_REG:  rb = {6'h00, interrupt_status_reg_q};
        `TMC_A_BCR1:  rb = bcr_q[0];
        `TMC_A_BCR2:  rb = bcr_q[1];
        `TMC_A_CR1:   rb = crr_q[0];
        `TMC_A_CR2:   rb = crr_q[1];
        default:      rb = 8'h00;
      endcase
      rv_d = 1'b1;
      rd_d = {24'h000000, rb};
      rr_d = is_mapped(s_axi_araddr) ? `TMC_RESP_OK : `TMC_RESP_ERR;
    end
    // Per-frame channel processing; no timeouts anywhere
    // waits indefinitely
    if (frame_tick) begin
      for (int c = 0; c < 2; c++) begin
        // channel 1 only in terminal mode; channel 0 always runs
        if (c == 0 || term) begin
          mi = rxv_q[`TMC_FR_MX + c*`TMC_FR_CH1];
          ri = rxv_q[`TMC_FR_MR + c*`TMC_FR_CH1];
          if (!mi && mon_q[c].mx_p) begin
            mon_d[c].rxd                = rxv_q[`TMC_FR_MON + c*`TMC_FR_CH1 +: 8];
            mon_d[c].unread             = 1'b1;
            mon_d[c].ack_due            = 1'b1;
            mon_d[c].in_msg             = 1'b1;
            mon_d[c].flags[`TMC_S_MDR]  = 1'b1;
          end
          if (mi && mon_q[c].mx_p && mon_q[c].in_msg) begin
            mon_d[c].in_msg             = 1'b0;
            mon_d[c].flags[`TMC_S_MER]  = 1'b1;
          end
          if (!mctl_q[c*`TMC_M_W + `TMC_M_MRC]) begin
            mon_d[c].mr_out = 1'b1;
            mon_d[c].blink  = 1'b0;
          end else if (mon_q[c].ack_due && !mon_q[c].unread) begin
            if (!mon_q[c].mr_out && !mon_q[c].blink) begin
              mon_d[c].mr_out = 1'b1;
              mon_d[c].blink  = 1'b1;
            end else begin
              mon_d[c].mr_out  = 1'b0;
              mon_d[c].blink   = 1'b0;
              mon_d[c].ack_due = 1'b0;
            end
          end
          // Transmitter
          case (mon_q[c].st)
            TMC_TX_IDLE: begin
              if (mctl_q[c*`TMC_M_W + `TMC_M_MXC]) begin
                mon_d[c].st     = TMC_TX_WAIT;
                mon_d[c].seen   = 1'b0;
                mon_d[c].tx_new = 1'b0;
                mon_d[c].mac    = 1'b1;
              end
            end
            TMC_TX_WAIT: begin
              if (mon_q[c].mr_p && !ri) begin
                mon_d[c].st                = TMC_TX_ACKED;
                mon_d[c].seen              = 1'b1;
                mon_d[c].flags[`TMC_S_MDA] = 1'b1;
              end
            end
            TMC_TX_ACKED: begin
              if (mon_q[c].tx_new) begin
                mon_d[c].st     = TMC_TX_BLINK;
                mon_d[c].tx_new = 1'b0;
              end
            end
            TMC_TX_BLINK: mon_d[c].st = TMC_TX_WAIT;
            default:      mon_d[c].st = TMC_TX_IDLE;
          endcase
          if (mon_q[c].seen && mon_q[c].st != TMC_TX_IDLE && ri && mon_q[c].mr_p) begin
            mon_d[c].flags[`TMC_S_MAB] = 1'b1;
            mon_d[c].seen              = 1'b0;
          end
          if (!mctl_q[c*`TMC_M_W + `TMC_M_MXC]) begin
            mon_d[c].st = TMC_TX_IDLE;
          end
          if (!mctl_q[c*`TMC_M_W + `TMC_M_MXC] && ri && mon_q[c].mr_p) begin
            mon_d[c].mac = 1'b0;
          end
          mon_d[c].mx_p = mi;
          mon_d[c].mr_p = ri;
        end else begin
          mon_d[c].st     = TMC_TX_IDLE;
          mon_d[c].mac    = 1'b0;
          mon_d[c].mr_out = 1'b1;
          mon_d[c].mx_p   = 1'b1;
          mon_d[c].mr_p   = 1'b1;
        end
        if (term) begin
          if (cc[c] != 2'h3) begin
            bcr_d[c] = rxv_q[`TMC_FR_B + c*8 +: 8];
          end
          case (cc[c])
            2'h0, 2'h1: crr_d[c] = rxv_q[`TMC_FR_IC + c*8 +: 8];
            2'h3:       crr_d[c] = rxv_q[`TMC_FR_B + c*8 +: 8];
            default:    crr_d[c] = 8'h00;
          endcase
        end
      end
      // double look on channel 0 code
      ci0p_d = c0;
      if (c0 == ci0p_q && c0 != cmd0_receive_reg_q) begin
        cmd0_receive_reg_d              = c0;
        interrupt_status_reg_d[`TMC_I_CI0]  = 1'b1;
      end
      // channel 1 change flagged at once
      if (term && rxv_q[`TMC_FR_CI1 +: 6] != cmd1_receive_reg_q) begin
        cmd1_receive_reg_d              = rxv_q[`TMC_FR_CI1 +: 6];
        interrupt_status_reg_d[`TMC_I_CI1]  = 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int c = 0; c < 2; c++) begin
        mon_q[c] <= '{st: TMC_TX_IDLE, seen: 1'b0, txd: 8'hFF, tx_new: 1'b0, mac: 1'b0, rxd: 8'h00,
                      unread: 1'b0, ack_due: 1'b0, mr_out: 1'b1, blink: 1'b0, in_msg: 1'b0,
                      mx_p: 1'b1, mr_p: 1'b1, flags: 4'h0};
        bcr_q[c] <= 8'h00;
        crr_q[c] <= 8'h00;
        crw_q[c] <= 8'hFF;
      end
      ctrl_q <= 6'h00;
      mctl_q <= 6'h00;
      cmd0_receive_reg_q <= 4'hF;
      cmd0_transmit_reg_q <= 4'hF;
      ci0p_q <= 4'hF;
      cmd1_receive_reg_q <= 6'h3F;
      cmd1_transmit_reg_q <= 6'h3F;
      interrupt_status_reg_q <= 2'h0;
      awh_q  <= 1'b0;
      wh_q   <= 1'b0;
      bv_q   <= 1'b0;
      rv_q   <= 1'b0;
      awa_q  <= 8'h00;
      wd_q   <= 8'h00;
      ws_q   <= 1'b0;
      br_q   <= 2'h0;
      rr_q   <= 2'h0;
      rd_q   <= 32'h00000000;
    end else begin
      mon_q  <= mon_d;
      bcr_q  <= bcr_d;
      crr_q  <= crr_d;
      crw_q  <= crw_d;
      ctrl_q <= ctrl_d;
      mctl_q <= mctl_d;
      cmd0_receive_reg_q <= cmd0_receive_reg_d;
      cmd0_transmit_reg_q <= cmd0_transmit_reg_d;
      ci0p_q <= ci0p_d;
      cmd1_receive_reg_q <= cmd1_receive_reg_d;
      cmd1_transmit_reg_q <= cmd1_transmit_reg_d;
      interrupt_status_reg_q <= interrupt_status_reg_d;
      awh_q  <= awh_d;
      wh_q   <= wh_d;
      bv_q   <= bv_d;
      rv_q   <= rv_d;
      awa_q  <= awa_d;
      wd_q   <= wd_d;
      ws_q   <= ws_d;
      br_q   <= br_d;
      rr_q   <= rr_d;
      rd_q   <= rd_d;
    end
  end

  // ==========================================================
  // Assertions
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_idle_force;
    frame_tick && !mctl_q[`TMC_M_MXC] |=> txv[`TMC_FR_MX] && (mon_q[0].st == TMC_TX_IDLE);
  endproperty
  a_idle_force: assert property (p_idle_force) else $error("handshake not idle");

  property p_start_active;
    frame_tick && mon_q[0].st == TMC_TX_IDLE && mctl_q[`TMC_M_MXC] |=> !txv[`TMC_FR_MX] && mon_q[0].mac;
  endproperty
  a_start_active: assert property (p_start_active) else $error("transmit not started");

  property p_store;
    logic [7:0] b;
    (frame_tick && !rxv_q[`TMC_FR_MX] && mon_q[0].mx_p, b = rxv_q[`TMC_FR_MON +: 8])
      |=> mon_q[0].rxd == b && mon_q[0].flags[`TMC_S_MDR];
  endproperty
  a_store: assert property (p_store) else $error("byte not stored");

  property p_ack;
    frame_tick && mctl_q[`TMC_M_MXC] && mon_q[0].st == TMC_TX_WAIT && mon_q[0].mr_p && !rxv_q[`TMC_FR_MR]
      |=> mon_q[0].flags[`TMC_S_MDA] && mon_q[0].st == TMC_TX_ACKED;
  endproperty
  a_ack: assert property (p_ack) else $error("acknowledge missed");

  property p_end_rx;
    frame_tick && mon_q[0].in_msg && rxv_q[`TMC_FR_MX] && mon_q[0].mx_p |=> mon_q[0].flags[`TMC_S_MER];
  endproperty
  a_end_rx: assert property (p_end_rx) else $error("end of reception missed");

  property p_abort;
    frame_tick && mon_q[0].seen && mon_q[0].st != TMC_TX_IDLE && rxv_q[`TMC_FR_MR] && mon_q[0].mr_p
      |=> mon_q[0].flags[`TMC_S_MAB];
  endproperty
  a_abort: assert property (p_abort) else $error("abort missed");

  property p_ci0;
    frame_tick && rxv_q[`TMC_FR_CI0 +: 4] == ci0p_q && rxv_q[`TMC_FR_CI0 +: 4] != cmd0_receive_reg_q
      |=> interrupt_status_reg_q[`TMC_I_CI0] && cmd0_receive_reg_q == $past(rxv_q[`TMC_FR_CI0 +: 4]);
  endproperty
  a_ci0: assert property (p_ci0) else $error("code 0 not accepted");

  property p_ci0_hold;
    frame_tick && rxv_q[`TMC_FR_CI0 +: 4] != ci0p_q |=> $stable(cmd0_receive_reg_q);
  endproperty
  a_ci0_hold: assert property (p_ci0_hold) else $error("code 0 taken early");

  property p_ci1;
    frame_tick && term && rxv_q[`TMC_FR_CI1 +: 6] != cmd1_receive_reg_q |=> interrupt_status_reg_q[`TMC_I_CI1];
  endproperty
  a_ci1: assert property (p_ci1) else $error("code 1 change missed");

  property p_mac;
    mon_q[0].st != TMC_TX_IDLE |-> mon_q[0].mac;
  endproperty
  a_mac: assert property (p_mac) else $error("active status low in transfer");

  property p_ch1_off;
    !term |-> !oev[`TMC_FR_MX + `TMC_FR_CH1] && !oev[`TMC_FR_CI1];
  endproperty
  a_ch1_off: assert property (p_ch1_off) else $error("channel 1 driven outside terminal");

  c_msg_full: cover property (mon_q[0].st == TMC_TX_BLINK ##[1:1000] mon_q[0].flags[`TMC_S_MDA]);
  c_abort:    cover property (frame_tick ##1 mon_q[0].flags[`TMC_S_MAB]);
  c_ci0:      cover property (frame_tick ##1 interrupt_status_reg_q[`TMC_I_CI0]);
endmodule

// file: tb/testbench.sv
// Self-checking bench for the backplane message and command handler
`timescale 1ns/1ns
`include "tmc_map.svh"
module testbench;
  import tmc_pkg::*;
  logic        aclk = 1'b0, aresetn = 1'b0, tick, dout, doe;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, v;
  logic [1:0]  bresp, rresp, r;
  logic [95:0] txf = '1, rxf;
  tmc_link_s   link;
  int          err_total = 0, num_checks = 0;
  tmc_top dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .link_i(link),
    .link_dout(dout), .link_doe(doe));
  tmc_peer peer (.tx_frame(txf), .link_dout(dout), .link_doe(doe), .link(link), .rx_frame(rxf), .tick(tick));
  initial begin
    forever #25 aclk = ~aclk;
  end
  // ==========
  // Tasks
  task close_out;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task tmo;
    err_total++;
    $display("[FAIL] %0t wait bound used up", $time);
    close_out();
  endtask
  task wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid) break;
    end
    if (n == 60) tmo();
    bready <= 1'b0;
  endtask
  task rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 60; n++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid) break;
    end
    if (n == 60) tmo();
    d = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask
  task fr(input int n);
    logic t;
    int   k;
    repeat (n) begin
      t = tick;
      for (k = 0; k < 1000 && tick === t; k++) @(posedge aclk);
      if (k == 1000) tmo();
    end
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (4) @(posedge aclk);
    aresetn <= 1'b1;
    fr(2);
    rd(`TMC_A_GSTAT, v, r);
    chk(v, 32'h0);
    rd(8'h44, v, r);
    chk({30'h0, r}, {30'h0, `TMC_RESP_ERR});
    chk(32'({rxf[63:62], rxf[31:30]}), 32'hF);
    chk(rxf[95:64], 32'hFFFFFFFF);
    $display("idle test done");
    wr(`TMC_A_CMD0_TRANSMIT_REG, 32'hA);
    wr(`TMC_A_CMD1_TRANSMIT_REG, 32'h15);
    fr(2);
    wr(`TMC_A_INTERRUPT_STATUS_REG, 32'h3);
    txf[29:26] <= 4'h5;
    txf[61:56] <= 6'h2A;
    fr(3);
    chk(32'(rxf[29:26]), 32'hA);
    chk(32'(rxf[61:56]), 32'h15);
    rd(`TMC_A_CMD0_RECEIVE_REG, v, r);
    chk(v, 32'h5);
    rd(`TMC_A_CMD1_RECEIVE_REG, v, r);
    chk(v, 32'h2A);
    rd(`TMC_A_INTERRUPT_STATUS_REG, v, r);
    chk(v, 32'h3);
    $display("command test done");
    wr(`TMC_A_MTX0, 32'h3C);
    wr(`TMC_A_MCTL, 32'h2);
    fr(3);
    chk(32'({rxf[31], rxf[23:16]}), 32'h03C);
    rd(`TMC_A_GSTAT, v, r);
    chk(v, 32'h1);
    txf[30] <= 1'b0;
    fr(3);
    rd(`TMC_A_MSTAT, v, r);
    chk(v, 32'h4);
    wr(`TMC_A_MSTAT, 32'hFF);
    wr(`TMC_A_MTX0, 32'h81);
    fr(2);
    chk(32'(rxf[31]), 32'h1);
    fr(1);
    chk(32'({rxf[31], rxf[23:16]}), 32'h081);
    txf[30] <= 1'b1;
    fr(3);
    rd(`TMC_A_MSTAT, v, r);
    chk(v, 32'h8);
    wr(`TMC_A_MCTL, 32'h0);
    fr(4);
    chk(32'(rxf[31]), 32'h1);
    rd(`TMC_A_GSTAT, v, r);
    chk(v, 32'h0);
    $display("message transmit test done");
    wr(`TMC_A_MSTAT, 32'hFF);
    txf[55:48] <= 8'h77;
    txf[63] <= 1'b0;
    fr(3);
    rd(`TMC_A_MSTAT, v, r);
    chk(v, 32'h10);
    rd(`TMC_A_MRX1, v, r);
    chk(v, 32'h77);
    wr(`TMC_A_MCTL, 32'h8);
    fr(3);
    chk(32'(rxf[62]), 32'h0);
    wr(`TMC_A_MSTAT, 32'hFF);
    txf[63] <= 1'b1;
    txf[55:48] <= 8'h42;
    fr(1);
    txf[63] <= 1'b0;
    fr(2);
    rd(`TMC_A_MSTAT, v, r);
    chk(v, 32'h10);
    rd(`TMC_A_MRX1, v, r);
    chk(v, 32'h42);
    fr(2);
    chk(32'(rxf[62]), 32'h1);
    fr(1);
    chk(32'(rxf[62]), 32'h0);
    wr(`TMC_A_MSTAT, 32'hFF);
    txf[63] <= 1'b1;
    fr(4);
    rd(`TMC_A_MSTAT, v, r);
    chk(v, 32'h20);
    wr(`TMC_A_MCTL, 32'h0);
    fr(3);
    chk(32'(rxf[62]), 32'h1);
    $display("message receive test done");
    wr(`TMC_A_CR1, 32'h5A);
    txf[39:32] <= 8'hC3;
    wr(`TMC_A_CTRL, 32'h4);
    fr(3);
    chk(32'(rxf[39:32]), 32'h5A);
    rd(`TMC_A_CR1, v, r);
    chk(v, 32'hC3);
    wr(`TMC_A_CTRL, 32'h8);
    fr(3);
    chk(32'(rxf[7:0]), 32'h5A);
    rd(`TMC_A_CR1, v, r);
    chk(v, 32'h0);
    wr(`TMC_A_CTRL, 32'h1);
    fr(3);
    chk(32'(rxf[63:56]), 32'hFF);
    $display("mode test done");
    close_out();
  end
endmodule

// file: tb/tmc_peer.sv
// Backplane peer model: link clock, frame sync, line data, capture
`timescale 1ns/1ns
module tmc_peer (
  input  wire logic [95:0]   tx_frame,
  input  wire logic          link_dout,
  input  wire logic          link_doe,
  output tmc_pkg::tmc_link_s link,
  output logic [95:0]        rx_frame,
  output logic               tick
);
  import tmc_pkg::*;
  logic [95:0] cur;
  initial begin
    link = '{clk: 1'b0, fs: 1'b0, dat: 1'b1};
    rx_frame = '1;
    tick = 1'b0;
    #637;
    forever begin
      for (int i = 0; i < 96; i++) begin
        link.fs = (i == 0);
        link.dat = tx_frame[i];
        #200 link.clk = 1'b1;
        // Released slot reads the pull-up level
        cur[i] = link_doe ? link_dout : 1'b1;
        #200 link.clk = 1'b0;
      end
      rx_frame = cur;
      tick = ~tick;
    end
  end
endmodule
